// File: arith_defines.vh
// Constants for the arithmetic instruction unit: offsets, fields, opcodes, resets.
`ifndef ARITH_DEFINES_VH
`define ARITH_DEFINES_VH

// Register byte offsets.
`define OFS_WORK    12'h000
`define OFS_MEMB    12'h004
`define OFS_IMM     12'h008
`define OFS_FLAGS   12'h00c
`define OFS_CMD     12'h010
`define OFS_STATUS  12'h014

// Flag register bit positions.
`define FLAG_ZERO   0
`define FLAG_CARRY  1
`define FLAG_HALF   2
`define FLAG_WRAP   3

// Status register bit positions.
`define STAT_DONE   0
`define STAT_BADOP  1

// Operation codes written to the command register.
`define OP_ADD_AI   5'h00
`define OP_ADD_AM   5'h01
`define OP_ADD_MA   5'h02
`define OP_ADDC_AM  5'h03
`define OP_ADDC_MA  5'h04
`define OP_ADDC_A   5'h05
`define OP_ADDC_M   5'h06
`define OP_SUB_AI   5'h07
`define OP_SUB_AM   5'h08
`define OP_SUB_MA   5'h09
`define OP_SUBC_AM  5'h0a
`define OP_SUBC_MA  5'h0b
`define OP_SUBC_A   5'h0c
`define OP_SUBC_M   5'h0d
`define OP_INC      5'h0e
`define OP_DEC      5'h0f
`define OP_CLEAR    5'h10

// Reset values.
`define RST_BYTE    8'h00
`define RST_FLAGS   4'h0
`define RST_OPCODE  5'h00

`endif

// File: arith_instr_unit.v
// Arithmetic instruction unit of an 8-bit core, reached over APB.
//
// Overview of operation
// RULE1 - Add immediate to working register, all flags
// RULE2 - Add memory byte into working register
// RULE3 - Add working register into memory byte
// RULE4 - Add with carry, register or memory form
// RULE5 - Add carry to working register
// RULE6 - Add carry to memory byte
// RULE7 - Subtract immediate via two's complement add
// RULE8 - Working register minus memory into register
// RULE9 - Memory minus working register into memory
// RULE10 - Register minus memory minus carry
// RULE11 - Memory minus register minus carry
// RULE12 - Subtract carry from working register
// RULE13 - Subtract carry from memory byte
// RULE14 - Increment memory byte, update flags
// RULE15 - Decrement memory byte, update flags
// RULE16 - Clear memory byte, flags unchanged
// RULE17 - Zero, bit-3 half and signed overflow
// RULE18 - Carry is borrow on subtraction
`timescale 1ns/1ps
`include "arith_defines.vh"

module arith_instr_unit #(
  parameter ADDR_WIDTH = 12
) (
  input  wire                  mclk,
  input  wire                  resetn,
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [ADDR_WIDTH-1:0] paddr,
  input  wire [31:0]           pwdata,
  input  wire [3:0]            pstrb,
  output wire                  pready,
  output wire                  pslverr,
  output wire [31:0]           prdata
);

  // Reset synchroniser state.
  reg        rstSync1_reg;
  reg        rstSync2_reg;
  wire       rstN;

  // Architectural state.
  reg  [7:0] workingRegister_reg;
  reg  [7:0] memByte_reg;
  reg  [7:0] immByte_reg;
  reg        zeroFlag_reg;
  reg        carryFlag_reg;
  reg        halfOutFlag_reg;
  reg        signedWrapFlag_reg;
  reg  [4:0] lastOp_reg;
  reg        doneFlag_reg;
  reg        badOpFlag_reg;
  reg [31:0] readData_reg;

  // Bus decode.
  wire       setupPhase;
  wire       accessWrite;
  wire       addrHit;
  wire       lowLane;
  wire       cmdWrite;
  reg [31:0] readData_next;

  // Operation decode and datapath.
  reg  [7:0] opA;
  reg  [7:0] opB;
  reg        carryIn;
  reg        isSub;
  reg        toMem;
  reg        updFlags;
  reg        updHalf;
  reg        legalOp;
  reg        doClear;
  wire [4:0] opCode;
  wire [7:0] addend;
  wire       addIn;
  wire [10:0] aluOut;
  wire [7:0] result;
  wire       carryOut;
  wire       halfOut;
  wire       wrapOut;
  wire       zeroOut;

  // Sum of two bytes and a carry; returns {overflow, half carry, carry, sum}.
  function [10:0] arith;
    input [7:0] a;
    input [7:0] b;
    input       ci;
    reg   [4:0] lo;
    reg   [8:0] full;
    reg         ov;
    begin
      lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      ov   = (a[7] == b[7]) && (full[7] != a[7]);
      arith = {ov, lo[4], full[8], full[7:0]};
    end
  endfunction

  // True when the address names one of the mapped registers.
  function mapped;
    input [ADDR_WIDTH-1:0] addr;
    begin
      case (addr)
        `OFS_WORK, `OFS_MEMB, `OFS_IMM, `OFS_FLAGS, `OFS_CMD, `OFS_STATUS:
          mapped = 1'b1;
        default:
          mapped = 1'b0;
      endcase
    end
  endfunction

  // Reset release through two flip-flops; the second alone is used.
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end
    else
    begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end

  assign rstN = rstSync2_reg;

  // Zero-wait slave: read data is captured in setup, access ends at once.
  assign setupPhase  = psel && !penable;
  assign accessWrite = psel && penable && pwrite;
  assign addrHit     = mapped(paddr);
  assign lowLane     = pstrb[0];
  assign cmdWrite    = accessWrite && addrHit && lowLane && (paddr == `OFS_CMD);
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !addrHit;
  assign prdata      = readData_reg;
  assign opCode      = pwdata[4:0];

  // Read multiplexer; unmapped addresses read as zero.
  always @*
  begin
    readData_next = 32'h0000_0000;
    case (paddr)
      `OFS_WORK:   readData_next = {24'h000000, workingRegister_reg};
      `OFS_MEMB:   readData_next = {24'h000000, memByte_reg};
      `OFS_IMM:    readData_next = {24'h000000, immByte_reg};
      `OFS_FLAGS:  readData_next = {28'h0000000, signedWrapFlag_reg, halfOutFlag_reg,
                                    carryFlag_reg, zeroFlag_reg};
      `OFS_CMD:    readData_next = {27'h0, lastOp_reg};
      `OFS_STATUS: readData_next = {30'h0, badOpFlag_reg, doneFlag_reg};
      default:     readData_next = 32'h0000_0000;
    endcase
  end

  // Operand selection per operation; subtraction adds the complement.
  always @*
  begin
    opA      = workingRegister_reg;
    opB      = 8'h00;
    carryIn  = 1'b0;
    isSub    = 1'b0;
    toMem    = 1'b0;
    updFlags = 1'b1;
    updHalf  = 1'b1;
    legalOp  = 1'b1;
    doClear  = 1'b0;
    case (opCode)
      `OP_ADD_AI:
        opB = immByte_reg; // RULE1
      `OP_ADD_AM:
        opB = memByte_reg; // RULE2
      `OP_ADD_MA:
      begin
        opB   = memByte_reg; // RULE3
        toMem = 1'b1;
      end
      `OP_ADDC_AM:
      begin
        opB     = memByte_reg; // RULE4
        carryIn = carryFlag_reg;
      end
      `OP_ADDC_MA:
      begin
        opB     = memByte_reg; // RULE4
        carryIn = carryFlag_reg;
        toMem   = 1'b1;
      end
      `OP_ADDC_A:
        carryIn = carryFlag_reg; // RULE5
      `OP_ADDC_M:
      begin
        opA     = memByte_reg; // RULE6
        carryIn = carryFlag_reg;
        toMem   = 1'b1;
      end
      `OP_SUB_AI:
      begin
        opB   = immByte_reg; // RULE7
        isSub = 1'b1;
      end
      `OP_SUB_AM:
      begin
        opB   = memByte_reg; // RULE8
        isSub = 1'b1;
      end
      `OP_SUB_MA:
      begin
        opA   = memByte_reg; // RULE9
        opB   = workingRegister_reg;
        isSub = 1'b1;
        toMem = 1'b1;
      end
      `OP_SUBC_AM:
      begin
        opB     = memByte_reg; // RULE10
        carryIn = carryFlag_reg;
        isSub   = 1'b1;
      end
      `OP_SUBC_MA:
      begin
        opA     = memByte_reg; // RULE11
        opB     = workingRegister_reg;
        carryIn = carryFlag_reg;
        isSub   = 1'b1;
        toMem   = 1'b1;
      end
      `OP_SUBC_A:
      begin
        carryIn = carryFlag_reg; // RULE12
        isSub   = 1'b1;
      end
      `OP_SUBC_M:
      begin
        opA     = memByte_reg; // RULE13
        carryIn = carryFlag_reg;
        isSub   = 1'b1;
        toMem   = 1'b1;
        updHalf = 1'b0;
      end
      `OP_INC:
      begin
        opA     = memByte_reg; // RULE14
        carryIn = 1'b1;
        toMem   = 1'b1;
      end
      `OP_DEC:
      begin
        opA   = memByte_reg; // RULE15
        opB   = 8'h01;
        isSub = 1'b1;
        toMem = 1'b1;
      end
      `OP_CLEAR:
      begin
        toMem    = 1'b1; // RULE16
        doClear  = 1'b1;
        updFlags = 1'b0;
      end
      default:
      begin
        legalOp  = 1'b0;
        updFlags = 1'b0;
        updHalf  = 1'b0;
      end
    endcase
  end

  // One adder serves every form; a borrow is an absent carry.
  assign addend   = isSub ? ~opB : opB; // RULE7
  assign addIn    = isSub ? ~carryIn : carryIn;
  assign aluOut   = arith(opA, addend, addIn);
  assign result   = doClear ? 8'h00 : aluOut[7:0];
  assign carryOut = aluOut[8] ^ isSub; // RULE18
  assign halfOut  = aluOut[9] ^ isSub; // RULE17
  assign wrapOut  = aluOut[10]; // RULE17
  assign zeroOut  = (aluOut[7:0] == 8'h00); // RULE17

  // Capture read data during the setup phase.
  always @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
      readData_reg <= 32'h0000_0000;
    else if (setupPhase)
      readData_reg <= readData_next;
  end

  // Operand registers: software writes, or a result from the datapath.
  always @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      workingRegister_reg <= `RST_BYTE;
      memByte_reg         <= `RST_BYTE;
      immByte_reg         <= `RST_BYTE;
    end
    else if (cmdWrite && legalOp)
    begin
      if (toMem)
        memByte_reg <= result; // RULE3
      else
        workingRegister_reg <= result; // RULE2
    end
    else if (accessWrite && lowLane)
    begin
      if (paddr == `OFS_WORK)
        workingRegister_reg <= pwdata[7:0];
      if (paddr == `OFS_MEMB)
        memByte_reg <= pwdata[7:0];
      if (paddr == `OFS_IMM)
        immByte_reg <= pwdata[7:0];
    end
  end

  // Flags: loaded by software, or updated by an operation that affects them.
  always @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      zeroFlag_reg       <= 1'b0;
      carryFlag_reg      <= 1'b0;
      halfOutFlag_reg    <= 1'b0;
      signedWrapFlag_reg <= 1'b0;
    end
    else if (cmdWrite && updFlags)
    begin
      zeroFlag_reg       <= zeroOut; // RULE17
      carryFlag_reg      <= carryOut; // RULE18
      signedWrapFlag_reg <= wrapOut;
      if (updHalf)
        halfOutFlag_reg <= halfOut; // RULE13
    end
    else if (accessWrite && lowLane && (paddr == `OFS_FLAGS))
    begin
      zeroFlag_reg       <= pwdata[`FLAG_ZERO];
      carryFlag_reg      <= pwdata[`FLAG_CARRY];
      halfOutFlag_reg    <= pwdata[`FLAG_HALF];
      signedWrapFlag_reg <= pwdata[`FLAG_WRAP];
    end
  end

  // Last command and sticky status; a new event wins over a clearing write.
  always @(posedge mclk or negedge rstN)
  begin
    if (!rstN)
    begin
      lastOp_reg    <= `RST_OPCODE;
      doneFlag_reg  <= 1'b0;
      badOpFlag_reg <= 1'b0;
    end
    else
    begin
      if (cmdWrite)
        lastOp_reg <= opCode;
      if (cmdWrite && legalOp)
        doneFlag_reg <= 1'b1;
      else if (accessWrite && lowLane && (paddr == `OFS_STATUS) && pwdata[`STAT_DONE])
        doneFlag_reg <= 1'b0;
      if (cmdWrite && !legalOp)
        badOpFlag_reg <= 1'b1;
      else if (accessWrite && lowLane && (paddr == `OFS_STATUS) && pwdata[`STAT_BADOP])
        badOpFlag_reg <= 1'b0;
    end
  end

endmodule

// File: arith_instr_unit_sva.sv
// Concurrent checks on the APB port of the arithmetic unit.
`timescale 1ns/1ps
`include "arith_defines.vh"
module arith_instr_unit_sva #(
  parameter ADDR_WIDTH = 12
) (
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [31:0]           prdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Access-phase decodes shared by the checks.
  wire acc = psel && penable;
  wire rdAcc = acc && !pwrite;
  wire bad = (paddr[1:0] != 2'b00) || (paddr > `OFS_STATUS);

  ready_const_a: assert property (pready) else $error("pready low");
  err_access_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
  err_unmapped_a: assert property (acc && bad |-> pslverr) else $error("no error on unmapped");
  err_mapped_a: assert property (acc && !bad |-> !pslverr) else $error("error on mapped");
  data_hold_a: assert property ($past(!(psel && !penable)) |-> $stable(prdata))
    else $error("read data moved outside setup");
  unmapped_zero_a: assert property (rdAcc && bad |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (rdAcc |-> prdata[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  flag_width_a: assert property (rdAcc && paddr == `OFS_FLAGS |-> prdata[7:4] == 4'h0)
    else $error("spare flag bits set");
  clear_mem_a: assert property ((acc && pwrite && pstrb[0] && paddr == `OFS_CMD
    && pwdata[4:0] == `OP_CLEAR) ##1 (psel && !penable && !pwrite && paddr == `OFS_MEMB)
    |=> prdata == 32'h0) else $error("clear left memory byte nonzero");

  // Main scenarios reached by the bench.
  cover property (acc && pwrite && paddr == `OFS_CMD);
  cover property (acc && pslverr);
  cover property (rdAcc && paddr == `OFS_STATUS && prdata[1]);
endmodule

// File: test_arith_instr_unit.sv
// Self-checking bench comparing the arithmetic unit with a byte-level model.
`timescale 1ns/1ps
`include "arith_defines.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_arith_instr_unit;
  reg         mclk = 1'b0;
  reg         resetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg [11:0]  paddr = 12'h000;
  reg [31:0]  pwdata = 32'h0;
  reg [3:0]   pstrb = 4'h0;
  wire        pready;
  wire        pslverr;
  wire [31:0] prdata;
  integer     errors = 0;
  integer     checked = 0;
  integer     op;
  reg [31:0]  seed = 32'd70;
  reg [31:0]  rv;
  reg         er;
  reg [11:0]  a;
  reg [7:0]   wk = 8'h00, mb = 8'h00, im = 8'h00;
  reg [3:0]   fl = 4'h0;
  reg [4:0]   cm = 5'h00;
  reg [1:0]   st = 2'h0;

  // The clock toggles every half period.
  always #5 mclk = ~mclk;

  arith_instr_unit i_arith_instr_unit (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata));

  // Xorshift step for the random stimulus.
  function [31:0] nx(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      nx = t ^ (t << 5);
    end
  endfunction

  // Model register read.
  function [31:0] mrd(input [11:0] ad);
    case (ad)
      `OFS_WORK: mrd = {24'h0, wk};
      `OFS_MEMB: mrd = {24'h0, mb};
      `OFS_IMM: mrd = {24'h0, im};
      `OFS_FLAGS: mrd = {28'h0, fl};
      `OFS_CMD: mrd = {27'h0, cm};
      `OFS_STATUS: mrd = {30'h0, st};
      default: mrd = 32'h0;
    endcase
  endfunction

  // Model of one command; subtraction adds the complement, carry means borrow.
  task exec(input [4:0] c);
    reg [7:0] x, y, yy;
    reg       s, u, d, ci;
    reg [8:0] sm;
    reg [4:0] h;
    begin
      {x, y, s, u, d} = 19'h0;
      case (c)
        0: {x, y, s, u, d} = {wk, im, 3'b000};
        1: {x, y, s, u, d} = {wk, mb, 3'b000};
        2: {x, y, s, u, d} = {wk, mb, 3'b001};
        3: {x, y, s, u, d} = {wk, mb, 3'b010};
        4: {x, y, s, u, d} = {wk, mb, 3'b011};
        5: {x, y, s, u, d} = {wk, 8'h00, 3'b010};
        6: {x, y, s, u, d} = {mb, 8'h00, 3'b011};
        7: {x, y, s, u, d} = {wk, im, 3'b100};
        8: {x, y, s, u, d} = {wk, mb, 3'b100};
        9: {x, y, s, u, d} = {mb, wk, 3'b101};
        10: {x, y, s, u, d} = {wk, mb, 3'b110};
        11: {x, y, s, u, d} = {mb, wk, 3'b111};
        12: {x, y, s, u, d} = {wk, 8'h00, 3'b110};
        13: {x, y, s, u, d} = {mb, 8'h00, 3'b111};
        14: {x, y, s, u, d} = {mb, 8'h01, 3'b001};
        15: {x, y, s, u, d} = {mb, 8'h01, 3'b101};
        default: {x, y, s, u, d} = 19'h0;
      endcase
      yy = s ? ~y : y;
      ci = (u & fl[1]) ^ s;
      sm = x + yy + ci;
      h = x[3:0] + yy[3:0] + ci;
      if (c > `OP_CLEAR)
        st[1] = 1'b1;
      else if (c == `OP_CLEAR)
        {st[0], mb} = 9'h100;
      else
      begin
        st[0] = 1'b1;
        fl = {(x[7] == yy[7]) && (sm[7] != x[7]), c == 5'd13 ? fl[2] : h[4] ^ s,
          sm[8] ^ s, sm[7:0] == 8'h0};
        if (d)
          mb = sm[7:0];
        else
          wk = sm[7:0];
      end
    end
  endtask

  task stop_test;
    begin
      if (errors == 0 && checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // APB transfer; psel stays high so the next setup may follow at once.
  task apb(input w, input [11:0] ad, input [31:0] dt, input [3:0] sb);
    begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, ad, dt, sb};
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
        @(posedge mclk);
      rv = prdata;
      er = pslverr;
    end
  endtask

  // Read and compare with the model.
  task rd(input [11:0] ad);
    begin
      apb(1'b0, ad, 32'h0, 4'h0);
      `CHK("rdata", mrd(ad), rv)
      `CHK("pslverr", ad > `OFS_STATUS, er)
    end
  endtask

  // Write and update the model when the low byte lane is enabled.
  task wr(input [11:0] ad, input [31:0] dt, input [3:0] sb);
    begin
      apb(1'b1, ad, dt, sb);
      `CHK("pslverr", ad > `OFS_STATUS, er)
      if (sb[0])
        case (ad)
          `OFS_WORK: wk = dt[7:0];
          `OFS_MEMB: mb = dt[7:0];
          `OFS_IMM: im = dt[7:0];
          `OFS_FLAGS: fl = dt[3:0];
          `OFS_CMD:
          begin
            cm = dt[4:0];
            exec(dt[4:0]);
          end
          `OFS_STATUS: st = st & ~dt[1:0];
          default: st = st;
        endcase
    end
  endtask

  // Reset, reset values, then every opcode with random operands and strobes.
  initial
  begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    for (a = 12'h000; a <= `OFS_STATUS; a = a + 12'h004)
      rd(a);
    for (op = 0; op < 32; op = op + 1)
      repeat (12)
      begin
        for (a = 12'h000; a <= `OFS_STATUS; a = a + 12'h004)
        begin
          seed = nx(seed);
          if (a != `OFS_CMD)
            wr(a, {seed[31:8], seed[16] ? seed[7:0] : {seed[7], {7{seed[6]}}}},
              seed[3:0] | {3'h0, seed[10:8] != 3'h0});
        end
        wr(`OFS_CMD, {seed[31:5], op[4:0]}, seed[3:0] | {3'h0, seed[14:12] != 3'h0});
        rd(`OFS_MEMB);
        rd(`OFS_WORK);
        rd(`OFS_FLAGS);
        rd(`OFS_CMD);
        rd(`OFS_STATUS);
        seed = nx(seed);
        a = seed[2] ? 12'h018 : {1'b1, seed[11:3], 2'b00};
        if (seed[0])
          wr(a, seed, 4'hf);
        else
          rd(a);
      end
    // A second reset in mid-run must bring every register back to its reset value.
    psel <= 1'b0;
    penable <= 1'b0;
    resetn <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    {wk, mb, im, fl} = {`RST_BYTE, `RST_BYTE, `RST_BYTE, `RST_FLAGS};
    {cm, st} = {`RST_OPCODE, 2'h0};
    repeat (3) @(posedge mclk);
    for (a = 12'h000; a <= `OFS_STATUS; a = a + 12'h004)
      rd(a);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    stop_test;
  end

  // Cuts the run short if a transfer hangs.
  initial
  begin
    #500000;
    errors = errors + 1;
    stop_test;
  end
endmodule

bind arith_instr_unit arith_instr_unit_sva #(.ADDR_WIDTH(ADDR_WIDTH)) i_arith_instr_unit_sva (
  .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .prdata(prdata));
